// ### common/lsau_pkg.sv
package lsau_pkg;

  // ----------------------------------------
  // Register port request
  // ----------------------------------------
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lsau_reg_req_t;

  // ----------------------------------------
  // One window measurement
  // ----------------------------------------
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
    logic [7:0] low;
    logic [7:0] high;
  } lsau_meas_t;

  // ----------------------------------------
  // Level fault sources
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] diode_fault;
    logic [3:0] fan_under;
    logic       timer_over;
    logic       overtemperature_flag;
    logic       latch;
  } lsau_src_t;

endpackage : lsau_pkg

// ### common/lsau_regs.svh
`ifndef LSAU_REGS_SVH
`define LSAU_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LSAU_OFS_STATUS1 8'h41
`define LSAU_OFS_STATUS2 8'h42
`define LSAU_OFS_MASK1   8'h74
`define LSAU_OFS_MASK2   8'h75

// ----------------------------------------
// Reset values and writable bits
// ----------------------------------------
`define LSAU_MASK1_RST   8'h00
`define LSAU_MASK2_RST   8'h00
`define LSAU_MASK1_USED  8'hF6
`define LSAU_MASK2_USED  8'hFE
`define LSAU_UNMAPPED    8'h00

// ----------------------------------------
// Primary status and mask fields
// ----------------------------------------
`define LSAU_ST1_SUMMARY 7
`define LSAU_ST1_R2T     6
`define LSAU_ST1_LT      5
`define LSAU_ST1_R1T     4
`define LSAU_ST1_MAIN    2
`define LSAU_ST1_CORE    1

// ----------------------------------------
// Secondary status and mask fields; the latch bit has no mask field
// ----------------------------------------
`define LSAU_ST2_D2      7
`define LSAU_ST2_D1      6
`define LSAU_ST2_F4P     5
`define LSAU_ST2_FAN_THREE_FLAG    4
`define LSAU_ST2_FAN_TWO_FLAG    3
`define LSAU_ST2_FAN_ONE_FLAG    2
`define LSAU_ST2_OVT     1
`define LSAU_ST2_LATCH   0

// ----------------------------------------
// Source counts
// ----------------------------------------
`define LSAU_N_WINDOW    5
`define LSAU_N_FANS      4

`endif

// ### logic/lsau_alert_unit.sv
`include "lsau_regs.svh"

module lsau_alert_unit #(
  parameter int N_WINDOW = `LSAU_N_WINDOW,
  parameter int N_FANS   = `LSAU_N_FANS
) (
  // Clock and reset
  input  wire logic                           sys_clk_i,
  input  wire logic                           rst_n_i,
  // Register port
  input  wire lsau_pkg::lsau_reg_req_t        reg_req_i,
  output logic [7:0]                          rd_data_o,
  // Sources
  input  wire lsau_pkg::lsau_meas_t [4:0]     meas_i,
  input  wire lsau_pkg::lsau_src_t            src_i,
  // Pin configuration
  input  wire logic                           alert_en_i,
  input  wire logic                           timer_mode_i,
  // Alert pin
  input  wire logic                           alert_i,
  output logic                                alert_o,
  output logic                                alert_oe_n_o,
  output logic                                alert_line_o
);
  import lsau_pkg::*;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (N_WINDOW != `LSAU_N_WINDOW || N_FANS != `LSAU_N_FANS) begin : g_bad_param
    $error("lsau_alert_unit: source counts are fixed by the register layout");
  end

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic [4:0] win_oor;
  logic [7:0] cond1;
  logic [7:0] cond2;
  logic [7:0] flag1;
  logic [7:0] flag2;
  logic [7:0] status1;
  logic [7:0] mask1;
  logic [7:0] mask2;
  logic       read1;
  logic       read2;
  logic       m2_all;
  logic       grp1;
  logic       grp2;
  logic       alert_req;
  logic       pin_meta;

  // ----------------------------------------
  // Window comparators
  // ----------------------------------------
  // Index 0 core, 1 main, 2 remote one, 3 local, 4 remote two
  for (genvar c = 0; c < 5; c++) begin : g_win
    lsau_window_cmp u_cmp (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .meas_i    (meas_i[c]),
      .oor_o     (win_oor[c])
    );
  end

  // ----------------------------------------
  // Conditions
  // ----------------------------------------
  always_comb begin
    cond1 = 8'h00;
    cond1[`LSAU_ST1_R2T]  = win_oor[4];
    cond1[`LSAU_ST1_LT]   = win_oor[3];
    cond1[`LSAU_ST1_R1T]  = win_oor[2];
    cond1[`LSAU_ST1_MAIN] = win_oor[1];
    cond1[`LSAU_ST1_CORE] = win_oor[0];
  end

  always_comb begin
    cond2 = 8'h00;
    cond2[`LSAU_ST2_D2]    = src_i.diode_fault[1];
    cond2[`LSAU_ST2_D1]    = src_i.diode_fault[0];
    cond2[`LSAU_ST2_F4P]   = timer_mode_i ? src_i.timer_over : src_i.fan_under[3];
    cond2[`LSAU_ST2_FAN_THREE_FLAG]  = src_i.fan_under[2];
    cond2[`LSAU_ST2_FAN_TWO_FLAG]  = src_i.fan_under[1];
    cond2[`LSAU_ST2_FAN_ONE_FLAG]  = src_i.fan_under[0];
    cond2[`LSAU_ST2_OVT]   = src_i.overtemperature_flag;
    cond2[`LSAU_ST2_LATCH] = src_i.latch;
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  assign read1 = reg_req_i.rd && (reg_req_i.addr == `LSAU_OFS_STATUS1);
  assign read2 = reg_req_i.rd && (reg_req_i.addr == `LSAU_OFS_STATUS2);

  // Masks never reach here, so a masked source still records
  for (genvar b = 0; b < 8; b++) begin : g_flag
    lsau_sticky_bit #(.STICKY(1'b1)) u_st1 (
      .sys_clk_i  (sys_clk_i),
      .rst_n_i    (rst_n_i),
      .cond_i     (cond1[b]),
      .read_clr_i (read1),
      .flag_o     (flag1[b])
    );
    lsau_sticky_bit #(.STICKY(b != `LSAU_ST2_OVT)) u_st2 (
      .sys_clk_i  (sys_clk_i),
      .rst_n_i    (rst_n_i),
      .cond_i     (cond2[b]),
      .read_clr_i (read2),
      .flag_o     (flag2[b])
    );
  end

  always_comb begin
    status1 = flag1;
    status1[`LSAU_ST1_SUMMARY] = |flag2;
  end

  // ----------------------------------------
  // Mask registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mask1 <= `LSAU_MASK1_RST;
    end else if (reg_req_i.wr && reg_req_i.addr == `LSAU_OFS_MASK1) begin
      mask1 <= reg_req_i.wdata & `LSAU_MASK1_USED;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mask2 <= `LSAU_MASK2_RST;
    end else if (reg_req_i.wr && reg_req_i.addr == `LSAU_OFS_MASK2) begin
      mask2 <= reg_req_i.wdata & `LSAU_MASK2_USED;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Data answers one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rd_data_o <= `LSAU_UNMAPPED;
    end else if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `LSAU_OFS_STATUS1: rd_data_o <= status1;
        `LSAU_OFS_STATUS2: rd_data_o <= flag2;
        `LSAU_OFS_MASK1:   rd_data_o <= mask1;
        `LSAU_OFS_MASK2:   rd_data_o <= mask2;
        default:           rd_data_o <= `LSAU_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------
  // Alert combine
  // ----------------------------------------
  // Mask bit 0 does not exist, so the latch flag has no own mask
  assign m2_all = &mask2[7:1];
  assign grp1   = |(flag1[6:1] & ~mask1[6:1]);
  assign grp2   = m2_all ? ((|flag2) & ~mask1[`LSAU_ST1_SUMMARY])
                         : ((|(flag2[7:1] & ~mask2[7:1])) | flag2[`LSAU_ST2_LATCH]);
  assign alert_req = grp1 | grp2;

  // ----------------------------------------
  // Alert pin
  // ----------------------------------------
  // Open drain: only ever pulls low, never drives high
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      alert_o      <= 1'b0;
      alert_oe_n_o <= 1'b1;
    end else begin
      alert_o      <= 1'b0;
      alert_oe_n_o <= ~(alert_en_i & alert_req);
    end
  end

  // Wire level back for the host side view
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pin_meta     <= 1'b1;
      alert_line_o <= 1'b1;
    end else begin
      pin_meta     <= alert_i;
      alert_line_o <= pin_meta;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_summary;
    read1 |=> rd_data_o[`LSAU_ST1_SUMMARY] == ($past(flag2) != 8'h00);
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit wrong");

  property p_remote_two;
    meas_i[4].valid && (meas_i[4].value > meas_i[4].high) |-> ##2 flag1[`LSAU_ST1_R2T];
  endproperty
  a_remote_two: assert property (p_remote_two) else $error("remote two flag missing");

  property p_core_low;
    meas_i[0].valid && (meas_i[0].value <= meas_i[0].low) |-> ##2 flag1[`LSAU_ST1_CORE];
  endproperty
  a_core_low: assert property (p_core_low) else $error("core supply flag missing");

  property p_unused;
    status1[3] == 1'b0 && status1[0] == 1'b0 && mask1[0] == 1'b0 && mask1[3] == 1'b0 && mask2[0] == 1'b0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");

  property p_diode;
    src_i.diode_fault[1] |=> flag2[`LSAU_ST2_D2];
  endproperty
  a_diode: assert property (p_diode) else $error("diode two flag missing");

  property p_fan;
    src_i.fan_under[0] |=> flag2[`LSAU_ST2_FAN_ONE_FLAG];
  endproperty
  a_fan: assert property (p_fan) else $error("fan one flag missing");

  property p_timer;
    timer_mode_i && src_i.timer_over |=> flag2[`LSAU_ST2_F4P];
  endproperty
  a_timer: assert property (p_timer) else $error("timer flag missing");

  property p_ovt;
    flag2[`LSAU_ST2_OVT] == $past(src_i.overtemperature_flag);
  endproperty
  a_ovt: assert property (p_ovt) else $error("overtemperature flag not following");

  property p_latch;
    src_i.latch |=> flag2[`LSAU_ST2_LATCH];
  endproperty
  a_latch: assert property (p_latch) else $error("latch flag missing");

  property p_sticky;
    flag2[`LSAU_ST2_FAN_ONE_FLAG] && !read2 |=> flag2[`LSAU_ST2_FAN_ONE_FLAG];
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky flag lost");

  property p_read_clear;
    flag1[`LSAU_ST1_LT] && read1 && !cond1[`LSAU_ST1_LT] |=> !flag1[`LSAU_ST1_LT];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear");

  property p_alert_on;
    alert_en_i && flag1[`LSAU_ST1_LT] && !mask1[`LSAU_ST1_LT] |=> !alert_oe_n_o;
  endproperty
  a_alert_on: assert property (p_alert_on) else $error("alert not driven");

  property p_ool_mask;
    alert_en_i && m2_all && mask1[`LSAU_ST1_SUMMARY] && !grp1 |=> alert_oe_n_o;
  endproperty
  a_ool_mask: assert property (p_ool_mask) else $error("alert despite full mask");

  property p_disabled;
    !alert_en_i |=> alert_oe_n_o && !alert_o;
  endproperty
  a_disabled: assert property (p_disabled) else $error("alert while disabled");

  property p_fan_four;
    !timer_mode_i && src_i.fan_under[3] |=> flag2[`LSAU_ST2_F4P];
  endproperty
  a_fan_four: assert property (p_fan_four) else $error("fan four flag missing");

  property p_timer_select;
    timer_mode_i && !src_i.timer_over && !flag2[`LSAU_ST2_F4P] |=> !flag2[`LSAU_ST2_F4P];
  endproperty
  a_timer_select: assert property (p_timer_select) else $error("fan four leaked into timer flag");

  property p_ovt_alert;
    alert_en_i && flag2[`LSAU_ST2_OVT] && !mask2[`LSAU_ST2_OVT] |=> !alert_oe_n_o;
  endproperty
  a_ovt_alert: assert property (p_ovt_alert) else $error("overtemperature alert missing");

  property p_latch_alert;
    alert_en_i && flag2[`LSAU_ST2_LATCH] && !m2_all |=> !alert_oe_n_o;
  endproperty
  a_latch_alert: assert property (p_latch_alert) else $error("latch alert missing");

  property p_ool_live;
    alert_en_i && m2_all && !mask1[`LSAU_ST1_SUMMARY] && flag2 != 8'h00 |=> !alert_oe_n_o;
  endproperty
  a_ool_live: assert property (p_ool_live) else $error("summary alert missing");

  // Nothing unmasked is pending, so the pin must let go
  property p_mask_quiet;
    alert_en_i && (flag1[6:1] & ~mask1[6:1]) == 6'h00 && flag2 == 8'h00 |=> alert_oe_n_o;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("alert despite primary mask");

  property p_fan_masked;
    alert_en_i && flag2 == 8'h04 && mask2[`LSAU_ST2_FAN_ONE_FLAG] && !m2_all && !grp1 |=> alert_oe_n_o;
  endproperty
  a_fan_masked: assert property (p_fan_masked) else $error("alert despite fan mask");

  property p_timer_masked;
    alert_en_i && flag2 == 8'h20 && mask2[`LSAU_ST2_F4P] && !m2_all && !grp1 |=> alert_oe_n_o;
  endproperty
  a_timer_masked: assert property (p_timer_masked) else $error("alert despite timer mask");

  property p_window_hold;
    !meas_i[0].valid |=> $stable(win_oor[0]);
  endproperty
  a_window_hold: assert property (p_window_hold) else $error("window result moved without measurement");

  property p_unmapped_read;
    reg_req_i.rd && reg_req_i.addr != `LSAU_OFS_STATUS1 && reg_req_i.addr != `LSAU_OFS_STATUS2 &&
      reg_req_i.addr != `LSAU_OFS_MASK1 && reg_req_i.addr != `LSAU_OFS_MASK2 |=> rd_data_o == `LSAU_UNMAPPED;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  c_alert: cover property (alert_en_i && alert_req ##1 !alert_oe_n_o);
  c_clear: cover property (read2 && flag2 != 8'h00 ##1 flag2 == 8'h00);
  c_masked: cover property (flag2[`LSAU_ST2_FAN_ONE_FLAG] && mask2[`LSAU_ST2_FAN_ONE_FLAG]);
  c_ovt: cover property (flag2[`LSAU_ST2_OVT] ##1 !flag2[`LSAU_ST2_OVT]);
  c_window: cover property (win_oor[4] && flag1[`LSAU_ST1_R2T]);

endmodule : lsau_alert_unit

// ### logic/lsau_sticky_bit.sv
module lsau_sticky_bit #(
  parameter bit STICKY = 1'b1
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // Condition and read clear
  input  wire logic cond_i,
  input  wire logic read_clr_i,
  // Flag
  output logic      flag_o
);

  // Set wins over the read clear, so no event is lost
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (STICKY) begin
      flag_o <= cond_i | (flag_o & ~read_clr_i);
    end else begin
      flag_o <= cond_i;
    end
  end

endmodule : lsau_sticky_bit

// ### logic/lsau_window_cmp.sv
module lsau_window_cmp (
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               rst_n_i,
  // Measurement
  input  wire lsau_pkg::lsau_meas_t meas_i,
  // Result
  output logic                    oor_o
);
  import lsau_pkg::*;

  // Holds the last comparison until the next measurement
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      oor_o <= 1'b0;
    end else if (meas_i.valid) begin
      oor_o <= (meas_i.value > meas_i.high) || (meas_i.value <= meas_i.low);
    end
  end

endmodule : lsau_window_cmp

// ### tb/lsau_host_model.sv
module lsau_host_model (
  // Device side of the alert pin
  input  wire logic alert_i,
  input  wire logic alert_oe_n_i,
  // Resolved wire
  output logic      alert_wire_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-up on the host board; a released line is never left floating
  assign alert_wire_o = alert_oe_n_i ? 1'b1 : alert_i;
endmodule : lsau_host_model

// ### tb/tb_lsau_alert_unit.sv
module tb_lsau_alert_unit;
  timeunit 1ns;
  timeprecision 100ps;
  import lsau_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic             sys_clk_i;
  logic             rst_n_i;
  logic             alert_en;
  logic             timer_mode;
  logic             alert_wire;
  logic             alert_o;
  logic             alert_oe_n;
  logic             alert_line;
  logic [7:0]       rd_data;
  lsau_reg_req_t    req;
  lsau_meas_t [4:0] meas;
  lsau_src_t        src;
  int               n_errors = 0;
  int               compares = 0;
  localparam logic [8:0] SRC  [8] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004, 9'h001};
  localparam logic [7:0] EXP2 [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h20, 8'h01};
  localparam logic [7:0] ST1  [5] = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h40};

  lsau_alert_unit DUT (
    .sys_clk_i    (sys_clk_i),
    .rst_n_i      (rst_n_i),
    .reg_req_i    (req),
    .rd_data_o    (rd_data),
    .meas_i       (meas),
    .src_i        (src),
    .alert_en_i   (alert_en),
    .timer_mode_i (timer_mode),
    .alert_i      (alert_wire),
    .alert_o      (alert_o),
    .alert_oe_n_o (alert_oe_n),
    .alert_line_o (alert_line)
  );

  lsau_host_model HOST (
    .alert_i      (alert_o),
    .alert_oe_n_i (alert_oe_n),
    .alert_wire_o (alert_wire)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick

  task reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    #1 req = '{1'b0, 1'b1, a, v};
    @(posedge sys_clk_i);
    #1 req = '0;
  endtask : reg_wr

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    #1 req = '{1'b1, 1'b0, a, 8'h00};
    @(posedge sys_clk_i);
    #1 req = '0;
    chk(rd_data, exp);
  endtask : rd_chk

  task pulse_meas(input int i, input logic [7:0] v);
    @(posedge sys_clk_i);
    #1 meas[i] = '{1'b1, v, 8'h20, 8'h80};
    @(posedge sys_clk_i);
    #1 meas[i].valid = 1'b0;
  endtask : pulse_meas

  // Host style service: mask, see alert, read, poll, unmask
  task src_case(input logic [7:0] m1, m2, input logic [8:0] s, input logic tm, en,
                input logic [7:0] e2, input logic eoe);
    reg_wr(8'h74, m1);
    reg_wr(8'h75, m2);
    timer_mode = tm;
    alert_en   = en;
    src        = lsau_src_t'(s);
    tick(4);
    chk({7'h00, alert_oe_n}, {7'h00, eoe});
    chk({7'h00, alert_line}, {7'h00, eoe});
    rd_chk(8'h42, e2);
    rd_chk(8'h41, 8'h80);
    src = '0;
    rd_chk(8'h42, e2);
    rd_chk(8'h42, 8'h00);
    tick(3);
    chk({7'h00, alert_oe_n}, 8'h01);
    reg_wr(8'h74, 8'h00);
    reg_wr(8'h75, 8'h00);
    alert_en = 1'b1;
  endtask : src_case

  task stop_test;
    $display("counts: %0d compares, %0d errors", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    alert_en = 1'b1;
    timer_mode = 1'b0;
    req = '0;
    meas = '0;
    src = '0;
    repeat (5) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    chk({7'h00, alert_oe_n}, 8'h01);
    chk({7'h00, alert_o}, 8'h00);
    rd_chk(8'h41, 8'h00);
    rd_chk(8'h75, 8'h00);
    reg_wr(8'h74, 8'hFF);
    rd_chk(8'h74, 8'hF6);
    reg_wr(8'h75, 8'hFF);
    rd_chk(8'h75, 8'hFE);
    reg_wr(8'h41, 8'hFF);
    rd_chk(8'h41, 8'h00);
    reg_wr(8'h10, 8'hFF);
    rd_chk(8'h10, 8'h00);
    $display("test registers done");
    // Each sticky secondary source alone
    for (int k = 0; k < 8; k++) begin
      src_case(8'h00, 8'h00, SRC[k], k == 6, 1'b1, EXP2[k], 1'b0);
    end
    $display("test secondary sources done");
    src_case(8'h00, 8'h04, 9'h008, 1'b0, 1'b1, 8'h04, 1'b1);
    src_case(8'h00, 8'h20, 9'h004, 1'b1, 1'b1, 8'h20, 1'b1);
    src_case(8'h00, 8'hFE, 9'h001, 1'b0, 1'b1, 8'h01, 1'b0);
    src_case(8'h80, 8'hFE, 9'h001, 1'b0, 1'b1, 8'h01, 1'b1);
    src_case(8'h00, 8'h00, 9'h008, 1'b0, 1'b0, 8'h04, 1'b1);
    $display("test masks done");
    src = lsau_src_t'(9'h002);
    tick(3);
    chk({7'h00, alert_oe_n}, 8'h00);
    rd_chk(8'h42, 8'h02);
    src = '0;
    tick(3);
    chk({7'h00, alert_oe_n}, 8'h01);
    rd_chk(8'h42, 8'h00);
    $display("test overtemperature done");
    // Window edges: equal to low trips, above high trips, equal to high does not
    for (int m = 0; m < 2; m++) begin
      reg_wr(8'h74, m ? 8'hF6 : 8'h00);
      for (int i = 0; i < 5; i++) begin
        for (int j = 0; j < 2; j++) begin
          pulse_meas(i, j ? 8'h81 : 8'h20);
          tick(3);
          chk({7'h00, alert_oe_n}, m ? 8'h01 : 8'h00);
          rd_chk(8'h41, ST1[i]);
          pulse_meas(i, 8'h80);
          tick(2);
          rd_chk(8'h41, ST1[i]);
          rd_chk(8'h41, 8'h00);
        end
      end
    end
    $display("test windows done");
    stop_test();
  end

  // Whole run is well under a thousand cycles; this is far beyond it
  initial begin
    #200us;
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : tb_lsau_alert_unit
